// ---- src/fl_regs.sv ----
// register bank and control decode of the dual flash light driver
`timescale 1ns/1ps
// Notes on behaviour
// - 0x01..0x08 read/write, up to 0x0D read-only
// - enable register: sync, hardware triggers, channel switches
// - mode bits 3:2 select standby/IR/torch/flash
// - bit 6 selects level or edge trigger
// - monitor enable bit 0, threshold 2.9..3.6 V
// - bit 6 enables lockout, bits 7,2:1 reserved
// - flash code times 7.83 mA plus 3.91
// - torch code times 1.96 mA plus 0.98
// - second channel has own current registers
// - boost limit, frequency, pass mode, short detect
// - writing bit 7 resets; bits 6:4 reserved
// - torch ramp code selects 0..1024 ms
// - flash time-out code selects 40..1600 ms
// - fault flags clear on read or reset; shorts, heat, undervoltage and overvoltage block
// - deglitched light short returns mode to standby
// - pointer advances after every data byte
module fl_regs #(
  parameter logic [7:0] CHIP_IDENTITY   = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_REVISION = 8'h05  // arbitrary value
) (
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  input  wire fl_pkg::fl_bus_req_s BUS_REQ,
  output logic [7:0]              RD_DATA,
  output logic                    RD_VALID,
  input  wire fl_pkg::fl_fault_s  FAULT_EVT,
  input  wire logic               CH1_SHORT_RAW,
  input  wire logic               CH2_SHORT_RAW,
  input  wire logic [6:0]         LAST_FLASH_CODE,
  input  wire logic               STROBE_PIN,
  input  wire logic               TORCH_PIN,
  output fl_pkg::fl_cfg_s         CFG,
  output fl_pkg::fl_act_e         ACTION,
  output logic [20:0]             CH1_FLASH_UA,
  output logic [20:0]             CH2_FLASH_UA,
  output logic [20:0]             CH1_TORCH_UA,
  output logic [20:0]             CH2_TORCH_UA,
  output logic                    OP_BLOCKED
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] ptr_ff;        // register pointer
  logic [7:0] enable_ff;     // enable and mode
  logic [7:0] vmon_ff;       // input voltage monitor config
  logic [7:0] cur_ff [4];    // flash1, flash2, torch1, torch2
  logic [7:0] boost_ff;      // boost config, reset bit never stored
  logic [7:0] timing_ff;     // ramp and time-out
  logic [7:0] fault1_ff;     // primary latched flags
  logic [7:0] fault2_ff;     // secondary latched flags
  logic [7:0] last_ff;       // last flash value
  logic       sw_reset;      // write of 1 to the reset bit
  logic       wr_en;
  logic       mode_clear;    // a fault forces standby
  logic [7:0] nxt_fault1;
  logic [7:0] nxt_fault2;
  logic [1:0] short_hit;     // deglitched short per channel
  logic [11:0] glitch_ff [2];
  logic       strobe_q_ff;
  logic       torch_q_ff;
  logic       hw_latch_ff;   // edge-mode trigger latch
  logic       trig;          // pin level or latched edge

  assign wr_en    = BUS_REQ.wr_stb;
  assign sw_reset = wr_en && (ptr_ff == fl_pkg::ADDR_BOOST_CFG) && BUS_REQ.data[fl_pkg::BC_SWRST_BIT];

  // ---------------------------------------------------------------
  // pointer
  // ---------------------------------------------------------------
  // loads on an address byte, steps after every data byte either way
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ptr_ff <= fl_pkg::RST_ZERO;
    end else if (BUS_REQ.addr_load) begin
      ptr_ff <= BUS_REQ.data;
    end else if (BUS_REQ.wr_stb || BUS_REQ.rd_stb) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  // enable register; fault-driven mode clear beats a same-cycle write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      enable_ff <= fl_pkg::RST_ENABLE_MODE;
    end else if (sw_reset) begin
      enable_ff <= fl_pkg::RST_ENABLE_MODE;
    end else begin
      if (wr_en && ptr_ff == fl_pkg::ADDR_ENABLE_MODE) begin
        enable_ff <= BUS_REQ.data;
      end
      if (mode_clear) begin
        enable_ff[fl_pkg::EN_MODE_HI:fl_pkg::EN_MODE_LO] <= fl_pkg::FL_MODE_STANDBY;
      end
    end
  end

  // other configuration registers, reserved bits masked off
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vmon_ff   <= fl_pkg::RST_VMON_CFG;
      boost_ff  <= fl_pkg::RST_BOOST_CFG;
      timing_ff <= fl_pkg::RST_TIMING_CFG;
    end else if (sw_reset) begin
      vmon_ff   <= fl_pkg::RST_VMON_CFG;
      boost_ff  <= fl_pkg::RST_BOOST_CFG;
      timing_ff <= fl_pkg::RST_TIMING_CFG;
    end else if (wr_en) begin
      // unmapped or read-only pointers fall through untouched
      if (ptr_ff == fl_pkg::ADDR_VMON_CFG) begin
        vmon_ff <= BUS_REQ.data & fl_pkg::MASK_VMON_CFG;
      end else if (ptr_ff == fl_pkg::ADDR_BOOST_CFG) begin
        boost_ff <= BUS_REQ.data & fl_pkg::MASK_BOOST_CFG;
      end else if (ptr_ff == fl_pkg::ADDR_TIMING_CFG) begin
        timing_ff <= BUS_REQ.data & fl_pkg::MASK_TIMING_CFG;
      end
    end
  end

  // four current codes, one loop; second channel fully independent
  for (genvar gi = 0; gi < 4; gi++) begin : g_cur
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        cur_ff[gi] <= fl_pkg::RST_CURRENT;
      end else if (sw_reset) begin
        cur_ff[gi] <= fl_pkg::RST_CURRENT;
      end else if (wr_en && ptr_ff == fl_pkg::ADDR_CH1_FLASH_CUR + 8'(gi)) begin
        cur_ff[gi] <= BUS_REQ.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // short deglitch
  // ---------------------------------------------------------------
  // a short only counts while driving and with detection on; a
  // momentary dip restarts the count so noise never trips it
  for (genvar gc = 0; gc < 2; gc++) begin : g_short
    logic raw;
    assign raw = (gc == 0) ? CH1_SHORT_RAW : CH2_SHORT_RAW;
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        glitch_ff[gc] <= '0;
      end else if (raw && boost_ff[fl_pkg::BC_SHORT_BIT] && ACTION != fl_pkg::FL_ACT_IDLE
                   && glitch_ff[gc] != 12'(fl_pkg::SHORT_GLITCH_CYC)) begin
        glitch_ff[gc] <= glitch_ff[gc] + 12'h001;
      end else if (!raw) begin
        glitch_ff[gc] <= '0;
      end
    end
    assign short_hit[gc] = (glitch_ff[gc] == 12'(fl_pkg::SHORT_GLITCH_CYC) - 12'h001) && raw;
  end

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------
  // set wins over the read-clear so no event slips through
  always_comb begin
    nxt_fault1 = fault1_ff;
    nxt_fault2 = fault2_ff;
    if (BUS_REQ.rd_stb && ptr_ff == fl_pkg::ADDR_FAULT_PRIMARY) begin
      nxt_fault1 = fl_pkg::RST_ZERO;
    end
    if (BUS_REQ.rd_stb && ptr_ff == fl_pkg::ADDR_FAULT_SECONDARY) begin
      nxt_fault2 = fl_pkg::RST_ZERO;
    end
    nxt_fault1 = nxt_fault1 | {FAULT_EVT.sync_evt, FAULT_EVT.vout_short, short_hit[0], short_hit[1],
                               FAULT_EVT.cur_limit, FAULT_EVT.thermal,
                               FAULT_EVT.undervoltage && vmon_ff[fl_pkg::VM_LOCKOUT_BIT],
                               FAULT_EVT.flash_timeout};
    nxt_fault2 = nxt_fault2 | ({5'h00, FAULT_EVT.vmon_trip && vmon_ff[fl_pkg::VM_ENABLE_BIT],
                                FAULT_EVT.overvoltage, 1'b0} & fl_pkg::MASK_SECONDARY);
  end

  // shorts, output short, heat and overvoltage drop the mode bits
  assign mode_clear = (|short_hit) || FAULT_EVT.vout_short || FAULT_EVT.thermal
                      || FAULT_EVT.overvoltage;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault1_ff <= fl_pkg::RST_ZERO;
      fault2_ff <= fl_pkg::RST_ZERO;
    end else if (sw_reset) begin
      fault1_ff <= fl_pkg::RST_ZERO;
      fault2_ff <= fl_pkg::RST_ZERO;
    end else begin
      fault1_ff <= nxt_fault1;
      fault2_ff <= nxt_fault2;
    end
  end

  // blocking faults: all except sync, current limit, time-out and input monitor trip
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OP_BLOCKED <= 1'b0;
    end else begin
      OP_BLOCKED <= (|fault1_ff[6:4]) || fault1_ff[2] || fault1_ff[1] || fault2_ff[1];
    end
  end

  // last flash value sampled continuously
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      last_ff <= fl_pkg::RST_ZERO;
    end else begin
      last_ff <= {1'b0, LAST_FLASH_CODE} & fl_pkg::MASK_LAST_FLASH;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA  <= fl_pkg::RST_ZERO;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= BUS_REQ.rd_stb;
      if (BUS_REQ.rd_stb) begin
        if (ptr_ff == fl_pkg::ADDR_CHIP_IDENTITY) begin
          RD_DATA <= CHIP_IDENTITY;
        end else if (ptr_ff == fl_pkg::ADDR_ENABLE_MODE) begin
          RD_DATA <= enable_ff;
        end else if (ptr_ff == fl_pkg::ADDR_VMON_CFG) begin
          RD_DATA <= vmon_ff;
        end else if (ptr_ff >= fl_pkg::ADDR_CH1_FLASH_CUR && ptr_ff <= fl_pkg::ADDR_CH2_TORCH_CUR) begin
          RD_DATA <= cur_ff[2'(ptr_ff - fl_pkg::ADDR_CH1_FLASH_CUR)];
        end else if (ptr_ff == fl_pkg::ADDR_BOOST_CFG) begin
          RD_DATA <= boost_ff;
        end else if (ptr_ff == fl_pkg::ADDR_TIMING_CFG) begin
          RD_DATA <= timing_ff;
        end else if (ptr_ff == fl_pkg::ADDR_FAULT_PRIMARY) begin
          RD_DATA <= fault1_ff;
        end else if (ptr_ff == fl_pkg::ADDR_FAULT_SECONDARY) begin
          RD_DATA <= fault2_ff;
        end else if (ptr_ff == fl_pkg::ADDR_DEVICE_REVISION) begin
          RD_DATA <= DEVICE_REVISION;
        end else if (ptr_ff == fl_pkg::ADDR_LAST_FLASH) begin
          RD_DATA <= last_ff;
        end else begin
          RD_DATA <= fl_pkg::RST_ZERO;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger handling
  // ---------------------------------------------------------------
  // pins assumed clean; the controller keeps pulses long
  // edge mode latches until a flash time-out, edge mode off, or both pin enables off
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strobe_q_ff <= 1'b0;
      torch_q_ff  <= 1'b0;
      hw_latch_ff <= 1'b0;
    end else begin
      strobe_q_ff <= STROBE_PIN;
      torch_q_ff  <= TORCH_PIN;
      if (!enable_ff[fl_pkg::EN_EDGE_BIT] || FAULT_EVT.flash_timeout
          || !enable_ff[fl_pkg::EN_FLASH_HW_BIT] && !enable_ff[fl_pkg::EN_TORCH_HW_BIT]) begin
        hw_latch_ff <= 1'b0;
      end else if ((STROBE_PIN && !strobe_q_ff) || (TORCH_PIN && !torch_q_ff)) begin
        hw_latch_ff <= 1'b1;
      end
    end
  end

  assign trig = enable_ff[fl_pkg::EN_EDGE_BIT] ? hw_latch_ff : (STROBE_PIN || TORCH_PIN);

  // action from mode, enables and pins; standby while blocked
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ACTION <= fl_pkg::FL_ACT_IDLE;
    end else begin
      if (OP_BLOCKED) begin
        ACTION <= fl_pkg::FL_ACT_IDLE;
      end else begin
        case (fl_pkg::fl_mode_e'(enable_ff[fl_pkg::EN_MODE_HI:fl_pkg::EN_MODE_LO]))
          fl_pkg::FL_MODE_TORCH: ACTION <= fl_pkg::FL_ACT_INT_TORCH;
          fl_pkg::FL_MODE_FLASH: ACTION <= fl_pkg::FL_ACT_INT_FLASH;
          fl_pkg::FL_MODE_IR: begin
            ACTION <= (enable_ff[fl_pkg::EN_FLASH_HW_BIT] && trig) ? fl_pkg::FL_ACT_IR_ON : fl_pkg::FL_ACT_IDLE;
          end
          default: begin
            if (enable_ff[fl_pkg::EN_FLASH_HW_BIT] && trig) begin
              ACTION <= fl_pkg::FL_ACT_EXT_FLASH;
            end else if (enable_ff[fl_pkg::EN_TORCH_HW_BIT] && trig) begin
              ACTION <= fl_pkg::FL_ACT_EXT_TORCH;
            end else begin
              ACTION <= fl_pkg::FL_ACT_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  // ramp time in ms; code 0 means no ramp
  function automatic logic [10:0] ramp_ms(input logic [2:0] code);
    logic [10:0] r;
    r = (code == 3'h0) ? 11'd0 : (code == 3'h1) ? 11'd1 : 11'(11'd32 << (code - 3'h2));
    return r;
  endfunction : ramp_ms

  // flash time-out in ms, gaps filled along the progression
  function automatic logic [10:0] tout_ms(input logic [3:0] code);
    logic [10:0] r;
    if (code <= 4'h9) begin
      r = 11'(11'd40 * (11'(code) + 11'd1));
    end else if (code == 4'hA) begin
      r = 11'd600;
    end else if (code == 4'hB) begin
      r = 11'd800;
    end else begin
      r = 11'(11'd1000 + 11'd200 * 11'(code - 4'hC));
    end
    return r;
  endfunction : tout_ms

  // register copies to the analogue side, all from flip-flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CFG          <= '0;
      CH1_FLASH_UA <= '0;
      CH2_FLASH_UA <= '0;
      CH1_TORCH_UA <= '0;
      CH2_TORCH_UA <= '0;
    end else begin
      CFG.ch1_flash    <= cur_ff[0];
      CFG.ch2_flash    <= cur_ff[1];
      CFG.ch1_torch    <= cur_ff[2];
      CFG.ch2_torch    <= cur_ff[3];
      CFG.ch1_on       <= enable_ff[fl_pkg::EN_CH1_BIT];
      CFG.ch2_on       <= enable_ff[fl_pkg::EN_CH2_BIT];
      CFG.sync_en      <= enable_ff[fl_pkg::EN_SYNC_BIT];
      CFG.vmon_en      <= vmon_ff[fl_pkg::VM_ENABLE_BIT];
      CFG.lockout_en   <= vmon_ff[fl_pkg::VM_LOCKOUT_BIT];
      CFG.vmon_mv      <= fl_pkg::VMON_BASE_MV
                          + 12'(fl_pkg::VMON_STEP_MV * 12'(vmon_ff[fl_pkg::VM_LEVEL_HI:fl_pkg::VM_LEVEL_LO]));
      CFG.limit_high   <= boost_ff[fl_pkg::BC_LIMIT_BIT];
      CFG.freq_high    <= boost_ff[fl_pkg::BC_FREQ_BIT];
      CFG.pass_only    <= boost_ff[fl_pkg::BC_PASS_BIT];
      CFG.short_detect <= boost_ff[fl_pkg::BC_SHORT_BIT];
      CFG.ramp_ms      <= ramp_ms(timing_ff[fl_pkg::TM_RAMP_HI:fl_pkg::TM_RAMP_LO]);
      CFG.timeout_ms   <= tout_ms(timing_ff[fl_pkg::TM_TOUT_HI:fl_pkg::TM_TOUT_LO]);
      CH1_FLASH_UA     <= 21'(fl_pkg::FLASH_STEP_UA * 21'(cur_ff[0])) + fl_pkg::FLASH_BASE_UA;
      CH2_FLASH_UA     <= 21'(fl_pkg::FLASH_STEP_UA * 21'(cur_ff[1])) + fl_pkg::FLASH_BASE_UA;
      CH1_TORCH_UA     <= 21'(fl_pkg::TORCH_STEP_UA * 21'(cur_ff[2])) + fl_pkg::TORCH_BASE_UA;
      CH2_TORCH_UA     <= 21'(fl_pkg::TORCH_STEP_UA * 21'(cur_ff[3])) + fl_pkg::TORCH_BASE_UA;
    end
  end

endmodule : fl_regs

// ---- src/fl_pkg.sv ----
// package of constants and carrier types for the flash light driver register bank
package fl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CHIP_IDENTITY   = 8'h00;
  localparam logic [7:0] ADDR_ENABLE_MODE     = 8'h01;
  localparam logic [7:0] ADDR_VMON_CFG        = 8'h02;
  localparam logic [7:0] ADDR_CH1_FLASH_CUR   = 8'h03;
  localparam logic [7:0] ADDR_CH2_FLASH_CUR   = 8'h04;
  localparam logic [7:0] ADDR_CH1_TORCH_CUR   = 8'h05;
  localparam logic [7:0] ADDR_CH2_TORCH_CUR   = 8'h06;
  localparam logic [7:0] ADDR_BOOST_CFG       = 8'h07;
  localparam logic [7:0] ADDR_TIMING_CFG      = 8'h08;
  localparam logic [7:0] ADDR_FAULT_PRIMARY   = 8'h0A;
  localparam logic [7:0] ADDR_FAULT_SECONDARY = 8'h0B;
  localparam logic [7:0] ADDR_DEVICE_REVISION = 8'h0C;
  localparam logic [7:0] ADDR_LAST_FLASH      = 8'h0D;

  // ---------------------------------------------------------------
  // reset values and writable masks (zero bits are reserved)
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE_MODE = 8'h80;
  localparam logic [7:0] RST_VMON_CFG    = 8'h01;
  localparam logic [7:0] RST_CURRENT     = 8'h7F;
  localparam logic [7:0] RST_BOOST_CFG   = 8'h09;
  localparam logic [7:0] RST_TIMING_CFG  = 8'h1A;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] MASK_VMON_CFG   = 8'h79;
  localparam logic [7:0] MASK_BOOST_CFG  = 8'h0F;
  localparam logic [7:0] MASK_TIMING_CFG = 8'h7F;
  localparam logic [7:0] MASK_SECONDARY  = 8'h06;
  localparam logic [7:0] MASK_LAST_FLASH = 8'h7F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EN_CH1_BIT      = 0;
  localparam int EN_CH2_BIT      = 1;
  localparam int EN_MODE_LO      = 2;
  localparam int EN_MODE_HI      = 3;
  localparam int EN_TORCH_HW_BIT = 4;
  localparam int EN_FLASH_HW_BIT = 5;
  localparam int EN_EDGE_BIT     = 6;
  localparam int EN_SYNC_BIT     = 7;
  localparam int VM_ENABLE_BIT   = 0;
  localparam int VM_LEVEL_LO     = 3;
  localparam int VM_LEVEL_HI     = 5;
  localparam int VM_LOCKOUT_BIT  = 6;
  localparam int BC_LIMIT_BIT    = 0;
  localparam int BC_FREQ_BIT     = 1;
  localparam int BC_PASS_BIT     = 2;
  localparam int BC_SHORT_BIT    = 3;
  localparam int BC_SWRST_BIT    = 7;
  localparam int TM_TOUT_LO      = 0;
  localparam int TM_TOUT_HI      = 3;
  localparam int TM_RAMP_LO      = 4;
  localparam int TM_RAMP_HI      = 6;

  // ---------------------------------------------------------------
  // analogue scale figures (millivolt, microamp)
  // ---------------------------------------------------------------
  localparam logic [11:0] VMON_BASE_MV  = 12'd2900;
  localparam logic [11:0] VMON_STEP_MV  = 12'd100;
  localparam logic [20:0] FLASH_STEP_UA = 21'd7830;
  localparam logic [20:0] FLASH_BASE_UA = 21'd3910;
  localparam logic [20:0] TORCH_STEP_UA = 21'd1960;
  localparam logic [20:0] TORCH_BASE_UA = 21'd980;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SHORT_GLITCH_US = 256;
  localparam int SHORT_GLITCH_CYC = (SHORT_GLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operating mode field encoding
  typedef enum logic [1:0] {
    FL_MODE_STANDBY = 2'b00,
    FL_MODE_IR      = 2'b01,
    FL_MODE_TORCH   = 2'b10,
    FL_MODE_FLASH   = 2'b11
  } fl_mode_e;

  // resolved drive action
  typedef enum logic [2:0] {
    FL_ACT_IDLE      = 3'b000,
    FL_ACT_EXT_TORCH = 3'b001,
    FL_ACT_EXT_FLASH = 3'b011,
    FL_ACT_INT_TORCH = 3'b010,
    FL_ACT_INT_FLASH = 3'b110,
    FL_ACT_IR_ON     = 3'b111
  } fl_act_e;

  // byte access request from the serial slave engine
  typedef struct packed {
    logic       addr_load; // pulse: data is the register pointer
    logic       wr_stb;    // pulse: data is written at the pointer
    logic       rd_stb;    // pulse: byte at the pointer is fetched
    logic [7:0] data;
  } fl_bus_req_s;

  // fault events from the analogue side, one-cycle pulses
  typedef struct packed {
    logic sync_evt;
    logic vout_short;
    logic cur_limit;
    logic thermal;
    logic undervoltage;
    logic flash_timeout;
    logic vmon_trip;
    logic overvoltage;
  } fl_fault_s;

  // configuration presented to the analogue side
  typedef struct packed {
    logic [7:0]  ch1_flash;
    logic [7:0]  ch2_flash;
    logic [7:0]  ch1_torch;
    logic [7:0]  ch2_torch;
    logic        ch1_on;
    logic        ch2_on;
    logic        sync_en;
    logic        vmon_en;
    logic        lockout_en;
    logic [11:0] vmon_mv;
    logic        limit_high;
    logic        freq_high;
    logic        pass_only;
    logic        short_detect;
    logic [10:0] ramp_ms;
    logic [10:0] timeout_ms;
  } fl_cfg_s;

endpackage : fl_pkg

// ---- dv/fl_regs_monitor.sv ----
// checker of the flash light register bank ports
`timescale 1ns/1ps
module fl_regs_monitor (
  input wire logic                CLK,
  input wire logic                ARST_N,
  input wire fl_pkg::fl_bus_req_s BUS_REQ,
  input wire logic [7:0]          RD_DATA,
  input wire logic                RD_VALID,
  input wire fl_pkg::fl_fault_s   FAULT_EVT,
  input wire fl_pkg::fl_cfg_s     CFG,
  input wire fl_pkg::fl_act_e     ACTION,
  input wire logic [20:0]         CH1_FLASH_UA,
  input wire logic [20:0]         CH2_FLASH_UA,
  input wire logic [20:0]         CH1_TORCH_UA,
  input wire logic [20:0]         CH2_TORCH_UA,
  input wire logic                OP_BLOCKED
);
  // ------
  // one clock domain, so shared clocking and disable
  // ------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  read_answer_a: assert property (1 |=> RD_VALID == $past(BUS_REQ.rd_stb)) else $error("bad read valid");
  read_hold_a: assert property (!BUS_REQ.rd_stb |=> $stable(RD_DATA)) else $error("read byte moved");
  vout_block_a: assert property (FAULT_EVT.vout_short |-> ##2 OP_BLOCKED) else $error("short not blocking");
  heat_stop_a: assert property (FAULT_EVT.thermal |-> ##3 ACTION == fl_pkg::FL_ACT_IDLE) else $error("heat runs");
  // past term skips the first edge of a new block, before ACTION has caught up
  block_idle_a: assert property (OP_BLOCKED && $past(OP_BLOCKED) |-> ACTION == fl_pkg::FL_ACT_IDLE)
    else $error("drive while blocked");
  ovp_stop_a: assert property (FAULT_EVT.overvoltage |-> ##2 OP_BLOCKED ##1 ACTION == fl_pkg::FL_ACT_IDLE)
    else $error("overvoltage runs");
  flash_ua_a: assert property ($stable(CFG.ch1_flash) [*2] |-> CH1_FLASH_UA == CFG.ch1_flash * 21'd7830 + 21'd3910
    && CH2_FLASH_UA == CFG.ch2_flash * 21'd7830 + 21'd3910) else $error("flash estimate");
  torch_ua_a: assert property ($stable(CFG.ch2_torch) [*2] |-> CH2_TORCH_UA == CFG.ch2_torch * 21'd1960 + 21'd980
    && CH1_TORCH_UA == CFG.ch1_torch * 21'd1960 + 21'd980) else $error("torch estimate");
  cover property (RD_VALID);
  cover property (FAULT_EVT.vout_short);
  cover property (ACTION == fl_pkg::FL_ACT_INT_FLASH);
endmodule : fl_regs_monitor
bind fl_regs fl_regs_monitor u_mon (.*);

// ---- dv/fl_host_model.sv ----
// host side model issuing byte requests to the register bank
`timescale 1ns/1ps
module fl_host_model (
  input  wire logic           CLK,
  output fl_pkg::fl_bus_req_s BUS_REQ
);
  initial BUS_REQ = '0;
  // one request per edge; idle calls carry random data so a stale byte never looks held
  task automatic op(input logic [2:0] k, input logic [7:0] d);
    @(posedge CLK);
    BUS_REQ <= {k, d};
  endtask : op
endmodule : fl_host_model

// ---- dv/tb_fl_regs.sv ----
// self-checking bench of the flash light register bank
`timescale 1ns/1ps
module tb_fl_regs;
  // ------
  // signals and expectation tables
  // ------
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  fl_pkg::fl_bus_req_s req;
  fl_pkg::fl_fault_s   flt = '0;
  logic                sh1 = 1'b0;
  logic                trq = 1'b0;
  logic                tch = 1'b0;
  logic [6:0]          lfc;
  logic [7:0]          rdd;
  logic                rdv;
  logic                blk;
  fl_pkg::fl_cfg_s     cfg;
  fl_pkg::fl_act_e     act;
  logic [7:0]          exp_q[$];
  logic [7:0]          dflt[14];
  logic [7:0]          wv[14];
  logic [7:0]          msk[9] = '{8'h00, 8'hFF, 8'h79, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h7F};
  logic [10:0]         tout[16] = '{40, 80, 120, 160, 200, 240, 280, 320, 360, 400, 600, 800, 1000, 1200, 1400, 1600};
  logic [10:0]         ramp[8] = '{0, 1, 32, 64, 128, 256, 512, 1024};
  logic [2:0]          mact[4] = '{3'b000, 3'b000, 3'b010, 3'b110}; // idle, idle, torch, flash
  int                  err_total = 0;
  int                  checked = 0;
  int                  cyc = 0;
  always #50 clk = ~clk;
  fl_host_model host (.CLK(clk), .BUS_REQ(req));
  fl_regs DUT (.CLK(clk), .ARST_N(arst_n), .BUS_REQ(req), .RD_DATA(rdd), .RD_VALID(rdv), .FAULT_EVT(flt),
    .CH1_SHORT_RAW(sh1), .CH2_SHORT_RAW(sh1), .LAST_FLASH_CODE(lfc), .STROBE_PIN(trq), .TORCH_PIN(tch),
    .CFG(cfg), .ACTION(act), .CH1_FLASH_UA(), .CH2_FLASH_UA(), .CH1_TORCH_UA(), .CH2_TORCH_UA(), .OP_BLOCKED(blk));
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  // k: 4 pointer, 2 write, 1 read (v is then the expected byte), 0 idle
  task automatic bus(input logic [2:0] k, input logic [7:0] v);
    if (k[0]) exp_q.push_back(v);
    host.op(k, (k[2] | k[1]) ? v : 8'($urandom));
  endtask : bus
  task automatic wt(input int n);
    bus(3'd0, 8'h00);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic pulse(input logic [7:0] f);
    @(posedge clk);
    flt <= f;
    @(posedge clk);
    flt <= '0;
  endtask : pulse
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // ------
  // read watcher and hang guard
  // ------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
    if (rdv === 1'b1) chk("read byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, rdd);
  end
  initial begin
    lfc = 7'($urandom(6022));
    dflt = '{8'hA5, 8'h80, 8'h01, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h09, 8'h1A, 8'h00, 8'h00, 8'h00, 8'h05, {1'b0, lfc}};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    // defaults in one burst, then random writes over every address, masked read-back
    bus(3'd4, 8'h00);
    for (int i = 0; i < 14; i++) bus(3'd1, dflt[i]);
    bus(3'd4, 8'h00);
    for (int i = 0; i < 14; i++) begin
      wv[i] = 8'($urandom) & ((i == 7) ? 8'h7F : 8'hFF);
      bus(3'd2, wv[i]);
    end
    bus(3'd4, 8'h00);
    for (int i = 0; i < 14; i++) bus(3'd1, (i > 0 && i < 9) ? wv[i] & msk[i] : dflt[i]);
    bus(3'd4, 8'hFF);
    bus(3'd1, 8'h00);
    bus(3'd1, 8'hA5);
    // fault gating by the monitor register, then software reset clears flags and registers
    bus(3'd4, 8'h02);
    bus(3'd2, 8'h01);
    wt(2);
    pulse(8'h1B);
    wt(3);
    chk("blocked", 21'd1, 21'(blk));
    bus(3'd4, 8'h0B);
    bus(3'd1, 8'h06);
    bus(3'd4, 8'h07);
    bus(3'd2, 8'h80);
    bus(3'd4, 8'h0A);
    bus(3'd1, 8'h00);
    bus(3'd4, 8'h01);
    for (int i = 1; i < 9; i++) bus(3'd1, dflt[i]);
    // every time-out, ramp and threshold code
    for (int i = 0; i < 16; i++) begin
      bus(3'd4, 8'h08);
      bus(3'd2, {1'b0, i[2:0], i[3:0]});
      bus(3'd4, 8'h02);
      bus(3'd2, {2'b00, i[2:0], 3'b001});
      wt(3);
      chk("time-out", 21'(tout[i]), 21'(cfg.timeout_ms));
      chk("ramp", 21'(ramp[i % 8]), 21'(cfg.ramp_ms));
      chk("monitor mv", 21'(2900 + 100 * i[2:0]), 21'(cfg.vmon_mv));
    end
    for (int m = 0; m < 4; m++) begin
      bus(3'd4, 8'h01);
      bus(3'd2, 8'h81 | 8'(m * 4));
      wt(3);
      chk("mode action", 21'(mact[m]), 21'(act));
      chk("first channel", 21'd1, 21'(cfg.ch1_on));
    end
    pulse(8'h40);
    wt(3);
    chk("vout action", 21'd0, 21'(act));
    bus(3'd4, 8'h01);
    bus(3'd1, 8'h81);
    bus(3'd4, 8'h0A);
    bus(3'd1, 8'h40);
    bus(3'd4, 8'h01);
    bus(3'd2, 8'h89);
    wt(2);
    @(posedge clk) sh1 <= 1'b1;
    repeat (2570) @(posedge clk);
    sh1 <= 1'b0;
    wt(3);
    chk("short blocked", 21'd1, 21'(blk));
    bus(3'd4, 8'h01);
    bus(3'd1, 8'h81);
    bus(3'd4, 8'h0A);
    bus(3'd1, 8'h30);
    // level trigger on the torch pin, then an edge trigger on the strobe pin
    bus(3'd4, 8'h01);
    bus(3'd2, 8'h90);
    wt(2);
    @(posedge clk) tch <= 1'b1;
    wt(3);
    chk("level torch", 21'd1, 21'(act));
    @(posedge clk) tch <= 1'b0;
    wt(3);
    chk("level off", 21'd0, 21'(act));
    bus(3'd4, 8'h01);
    bus(3'd2, 8'hE0);
    wt(2);
    chk("edge idle", 21'd0, 21'(act));
    @(posedge clk) trq <= 1'b1;
    repeat (10001) @(posedge clk);
    trq <= 1'b0;
    wt(3);
    chk("edge flash", 21'd3, 21'(act));
    pulse(8'h04);
    wt(3);
    chk("time-out stop", 21'd0, 21'(act));
    chk("reads left", 21'd0, 21'(exp_q.size()));
    stop_test();
  end
endmodule : tb_fl_regs
